// *** design/ddzq_pkg.sv ***
// Constants and types of the calibration block
package ddzq_pkg;

  // Register byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CODE = 4'h8;
  localparam logic [3:0] ADDR_SPACING = 4'hC;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CRC_BIT = 2;
  localparam int CTRL_DM_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_000F;

  // Burst mode field encodings
  localparam logic [1:0] MODE_EIGHT = 2'h0;
  localparam logic [1:0] MODE_OTF = 2'h1;
  localparam logic [1:0] MODE_CHOP = 2'h2;

  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_FIRST = 1;
  localparam int ST_CURRENT = 2;
  localparam int ST_OFFENDER = 3;
  localparam int ST_DLL = 4;
  localparam int ST_SPACING_ERR = 8;
  localparam int ST_ZQ_REFUSED = 9;
  localparam int ST_QUIET_ERR = 10;
  localparam int ST_PIN_ERR = 11;
  localparam int ST_RECOVERY_ERR = 12;
  localparam int ST_UNSAFE = 13;
  localparam int ST_ERR_LSB = 8;
  localparam int ST_ERR_W = 6;

  // Spacing reset values
  localparam logic [7:0] SAME_GROUP_SPACING_RST = 8'h06;
  localparam logic [7:0] CROSS_GROUP_SPACING_RST = 8'h04;

  // Timing counts in clock cycles
  localparam logic [11:0] INIT_CAL_CYC = 12'h400;
  localparam logic [11:0] OPER_CAL_CYC = 12'h200;
  localparam logic [11:0] SHORT_CAL_CYC = 12'h080;
  localparam logic [11:0] SHORT_CORR_CYC = 12'h040;
  localparam logic [7:0] PRECHARGE_CYC = 8'h0C;
  localparam logic [7:0] WR_REC_CYC = 8'h0C;
  localparam logic [7:0] WR_REC_CRC_DM_CYC = 8'h10;
  localparam logic [7:0] WTR_CYC = 8'h04;
  localparam logic [7:0] WTR_CRC_DM_CYC = 8'h06;
  localparam logic [11:0] SRX_EXIT_CYC = 12'h100;
  localparam logic [11:0] DLL_LOCK_CYC = 12'h300;
  localparam logic [3:0] BEATS_HALF_EIGHT = 4'h4;
  localparam logic [3:0] BEATS_HALF_CHOP = 4'h2;
  localparam logic [3:0] MAX_EDGE_OFS = 4'h6;
  localparam logic [5:0] CODE_RESET = 6'h20;
  localparam logic [5:0] CODE_MAX = 6'h3F;
  localparam logic [5:0] CODE_MIN = 6'h00;
  localparam logic [6:0] SHORT_STEP_MAX = 7'h04;

  // Write masks, corruption pattern
  localparam logic [31:0] MASK_EIGHT = 32'hFFFF_FFFF;
  localparam logic [31:0] MASK_CHOP = 32'h0000_FFFF;
  localparam logic [31:0] CORRUPT_PAT = 32'hFFFF_FFFF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pin command codes
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_ACT = 4'h1,
    CMD_WR = 4'h2,
    CMD_WRA = 4'h3,
    CMD_RD = 4'h4,
    CMD_PRE = 4'h5,
    CMD_PREA = 4'h6,
    CMD_ZQ = 4'h7,
    CMD_SRX = 4'h8
  } ddzq_cmd_e;

  // Calibration engine states
  typedef enum logic [2:0] {
    CAL_IDLE = 3'h1,
    CAL_MEAS = 3'h2,
    CAL_XFER = 3'h4
  } ddzq_cal_e;

  // Controller pins
  typedef struct packed {
    logic cmd_valid;
    logic [3:0] cmd;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [3:0] col;
    logic a10;
    logic a12;
    logic [31:0] wdata;
    logic data_viol;
    logic strobe_viol;
    logic [3:0] edge_ofs;
    logic cke;
    logic odt;
    logic zq_comp;
  } ddzq_pin_s;

endpackage

// *** design/ddzq_mem.sv ***
// Data store, masked write, registered read
`timescale 1ns/1ps
`default_nettype none

module ddzq_mem #(
  parameter int DW = 32,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [DW-1:0] wmask,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Masked write, read data from a register
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
    end
    rdata <= mem[raddr];
  end

endmodule

`default_nettype wire

// *** design/ddzq_top.sv ***
// Device command logic: write violation recovery and impedance calibration
//
// Overview of operation
// - CRC+mask recovery counted after last data beat
// - Mode 00 eight, 10 chop, 01 per-command
// - Setup/hold fault hits addressed word only
// - Strobe faults tolerated within limits
// - Reads served after an offence
// - Same-group writes after long spacing
// - Cross-group writes after short spacing
// - All banks idle restores good writes
// - Long cal measures, then transfers codes
// - First long uses initial period, later operational
// - Short cal corrects within short period
// - Cal current off when done
// - Cal accepted during lock after exit
// - No self calibration; respect exit delay
// - Clock enable high, termination low, park kept
`timescale 1ns/1ps
`default_nettype none

module ddzq_top #(
  parameter int MEM_AW = 8,
  parameter logic [11:0] INIT_CYC = ddzq_pkg::INIT_CAL_CYC,
  parameter logic [11:0] OPER_CYC = ddzq_pkg::OPER_CAL_CYC,
  parameter logic [11:0] SHORT_CYC = ddzq_pkg::SHORT_CAL_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire ddzq_pkg::ddzq_pin_s PINS,
  output logic [31:0] RDATA,
  output logic RVALID,
  output logic [5:0] DRV_CODE,
  output logic [5:0] ODT_CODE,
  output logic ZQ_CURRENT_EN,
  output logic PARK_TERM_EN,
  output logic CAL_BUSY,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP
);

  typedef struct packed {
    ddzq_pkg::ddzq_pin_s p1;
    ddzq_pkg::ddzq_pin_s p2;
    logic [15:0] bank_open;
    logic [7:0] pre_cnt;
    logic [11:0] srx_cnt;
    logic [11:0] dll_cnt;
    ddzq_pkg::ddzq_cal_e cal_st;
    logic [11:0] cal_cnt;
    logic [11:0] cal_age;
    logic cal_long;
    logic first_cal;
    logic [6:0] step_cnt;
    logic [5:0] meas_code;
    logic [5:0] drv_code;
    logic [5:0] odt_code;
    logic [7:0] since_wr;
    logic wr_seen;
    logic [1:0] last_bg;
    logic offender;
    logic [3:0] beat_cnt;
    logic [7:0] rec_cnt;
    logic [7:0] wtr_cnt;
    logic [ddzq_pkg::ST_ERR_W-1:0] err;
    logic [3:0] ctrl;
    logic [15:0] spacing;
    logic rd_pend;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ddzq_state_s;

  ddzq_state_s s_r;
  ddzq_state_s s_nxt;
  logic mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_wmask;
  logic [MEM_AW-1:0] mem_raddr;
  logic [31:0] mem_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Bank index
  function automatic logic [3:0] bank_idx(input logic [1:0] bg, input logic [1:0] ba);
    bank_idx = {bg, ba};
  endfunction

  // Saturating countdown
  function automatic logic [11:0] dec12(input logic [11:0] v);
    dec12 = (v == 12'h000) ? 12'h000 : v - 12'h001;
  endfunction

  function automatic logic [7:0] dec8(input logic [7:0] v);
    dec8 = (v == 8'h00) ? 8'h00 : v - 8'h01;
  endfunction

  // Chop decision
  function automatic logic is_chop(input logic [1:0] mode, input logic a12);
    is_chop = (mode == ddzq_pkg::MODE_CHOP) || ((mode == ddzq_pkg::MODE_OTF) && !a12);
  endfunction

  // Status word
  function automatic logic [31:0] status_word(input ddzq_state_s s);
    status_word = 32'h0000_0000;
    status_word[ddzq_pkg::ST_BUSY] = (s.cal_st != ddzq_pkg::CAL_IDLE);
    status_word[ddzq_pkg::ST_FIRST] = s.first_cal;
    status_word[ddzq_pkg::ST_CURRENT] = (s.cal_st == ddzq_pkg::CAL_MEAS);
    status_word[ddzq_pkg::ST_OFFENDER] = s.offender;
    status_word[ddzq_pkg::ST_DLL] = (s.dll_cnt != 12'h000);
    status_word[ddzq_pkg::ST_ERR_LSB +: ddzq_pkg::ST_ERR_W] = s.err;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic [3:0] bi;
    logic chop;
    logic [31:0] err_set;
    logic [31:0] err_clr;
    logic busy;
    logic cmd_ok;
    logic [7:0] need;
    logic do_wr;
    logic [31:0] wword;
    bi = 4'h0;
    chop = 1'b0;
    err_set = '0;
    err_clr = '0;
    busy = 1'b0;
    cmd_ok = 1'b0;
    need = 8'h00;
    do_wr = 1'b0;
    wword = 32'h0000_0000;
    s_nxt = s_r;

    // Two-stage pin synchroniser
    s_nxt.p1 = PINS;
    s_nxt.p2 = s_r.p1;

    // Free-running timers
    s_nxt.pre_cnt = dec8(s_r.pre_cnt);
    s_nxt.srx_cnt = dec12(s_r.srx_cnt);
    s_nxt.dll_cnt = dec12(s_r.dll_cnt);
    s_nxt.rec_cnt = dec8(s_r.rec_cnt);
    s_nxt.wtr_cnt = dec8(s_r.wtr_cnt);
    s_nxt.since_wr = (s_r.since_wr == 8'hFF) ? 8'hFF : s_r.since_wr + 8'h01;
    s_nxt.rd_pend = 1'b0;

    // Recovery counted from the edge after the final data beat
    if (s_r.beat_cnt != 4'h0) begin
      s_nxt.beat_cnt = s_r.beat_cnt - 4'h1;
      if (s_r.beat_cnt == 4'h1) begin
        if (s_r.ctrl[ddzq_pkg::CTRL_CRC_BIT] && s_r.ctrl[ddzq_pkg::CTRL_DM_BIT]) begin
          s_nxt.rec_cnt = ddzq_pkg::WR_REC_CRC_DM_CYC;
          s_nxt.wtr_cnt = ddzq_pkg::WTR_CRC_DM_CYC;
        end else begin
          s_nxt.rec_cnt = ddzq_pkg::WR_REC_CYC;
          s_nxt.wtr_cnt = ddzq_pkg::WTR_CYC;
        end
      end
    end

    // Calibration engine
    busy = (s_r.cal_st != ddzq_pkg::CAL_IDLE);
    unique case (s_r.cal_st)
      ddzq_pkg::CAL_IDLE: begin
      end
      ddzq_pkg::CAL_MEAS: begin
        s_nxt.cal_cnt = dec12(s_r.cal_cnt);
        s_nxt.cal_age = s_r.cal_age + 12'h001;
        // Short runs are step-limited inside the correction window
        if (s_r.cal_long || ((s_r.cal_age < ddzq_pkg::SHORT_CORR_CYC) && (s_r.step_cnt != 7'h00))) begin
          if (s_r.p2.zq_comp && (s_r.meas_code != ddzq_pkg::CODE_MAX)) begin
            s_nxt.meas_code = s_r.meas_code + 6'h01;
            s_nxt.step_cnt = s_r.step_cnt - 7'h01;
          end else if (!s_r.p2.zq_comp && (s_r.meas_code != ddzq_pkg::CODE_MIN)) begin
            s_nxt.meas_code = s_r.meas_code - 6'h01;
            s_nxt.step_cnt = s_r.step_cnt - 7'h01;
          end
        end
        if (s_r.cal_cnt == 12'h001) begin
          s_nxt.cal_st = ddzq_pkg::CAL_XFER;
        end
      end
      ddzq_pkg::CAL_XFER: begin
        // Codes into the I/O, current off
        s_nxt.drv_code = s_r.meas_code;
        s_nxt.odt_code = s_r.meas_code;
        s_nxt.cal_st = ddzq_pkg::CAL_IDLE;
      end
      default: begin
        s_nxt.cal_st = ddzq_pkg::CAL_IDLE;
      end
    endcase

    // Pins that must hold during calibration
    if (busy && (!s_r.p2.cke || s_r.p2.odt)) begin
      err_set[ddzq_pkg::ST_PIN_ERR] = 1'b1;
    end

    // Command decode
    bi = bank_idx(s_r.p2.bg, s_r.p2.ba);
    chop = is_chop(s_r.ctrl[ddzq_pkg::CTRL_MODE_LSB +: 2], s_r.p2.a12);
    cmd_ok = s_r.p2.cmd_valid && (s_r.p2.cmd != ddzq_pkg::CMD_NOP);
    if (cmd_ok && busy) begin
      // Dropped and flagged while calibrating
      err_set[ddzq_pkg::ST_QUIET_ERR] = 1'b1;
    end else if (cmd_ok) begin
      case (s_r.p2.cmd)
        ddzq_pkg::CMD_ACT: begin
          s_nxt.bank_open[bi] = 1'b1;
        end
        ddzq_pkg::CMD_WR, ddzq_pkg::CMD_WRA: begin
          need = (s_r.p2.bg == s_r.last_bg) ? s_r.spacing[7:0] : s_r.spacing[15:8];
          if (s_r.wr_seen && (s_r.since_wr < need)) begin
            err_set[ddzq_pkg::ST_SPACING_ERR] = 1'b1;
          end
          do_wr = 1'b1;
          wword = s_r.p2.wdata;
          // Only the addressed word takes the damage
          if (s_r.p2.data_viol || s_r.p2.strobe_viol || s_r.offender) begin
            wword = s_r.p2.wdata ^ ddzq_pkg::CORRUPT_PAT;
          end
          if (s_r.p2.strobe_viol) begin
            s_nxt.offender = 1'b1;
            if (s_r.ctrl[ddzq_pkg::CTRL_CRC_BIT]
                || (s_r.ctrl[ddzq_pkg::CTRL_MODE_LSB +: 2] == ddzq_pkg::MODE_OTF)
                || (s_r.p2.edge_ofs > ddzq_pkg::MAX_EDGE_OFS)) begin
              err_set[ddzq_pkg::ST_UNSAFE] = 1'b1;
            end
          end
          s_nxt.since_wr = 8'h01;
          s_nxt.wr_seen = 1'b1;
          s_nxt.last_bg = s_r.p2.bg;
          s_nxt.beat_cnt = chop ? ddzq_pkg::BEATS_HALF_CHOP : ddzq_pkg::BEATS_HALF_EIGHT;
          if (s_r.p2.cmd == ddzq_pkg::CMD_WRA) begin
            s_nxt.bank_open[bi] = 1'b0;
          end
        end
        ddzq_pkg::CMD_RD: begin
          // Reads stay served after an offence
          if (s_r.wtr_cnt != 8'h00 || s_r.beat_cnt != 4'h0) begin
            err_set[ddzq_pkg::ST_RECOVERY_ERR] = 1'b1;
          end
          if (s_r.bank_open[bi]) begin
            s_nxt.rd_pend = 1'b1;
          end
        end
        ddzq_pkg::CMD_PRE, ddzq_pkg::CMD_PREA: begin
          if (s_r.rec_cnt != 8'h00 || s_r.beat_cnt != 4'h0) begin
            err_set[ddzq_pkg::ST_RECOVERY_ERR] = 1'b1;
          end
          if (s_r.p2.cmd == ddzq_pkg::CMD_PREA) begin
            s_nxt.bank_open = 16'h0000;
          end else begin
            s_nxt.bank_open[bi] = 1'b0;
          end
          s_nxt.pre_cnt = ddzq_pkg::PRECHARGE_CYC;
          if (s_nxt.bank_open == 16'h0000) begin
            s_nxt.offender = 1'b0;
          end
        end
        ddzq_pkg::CMD_ZQ: begin
          // Refused with open banks or the precharge or exit timer running
          if (s_r.bank_open != 16'h0000 || s_r.pre_cnt != 8'h00 || s_r.srx_cnt != 12'h000) begin
            err_set[ddzq_pkg::ST_ZQ_REFUSED] = 1'b1;
          end else begin
            // Lock counter does not block calibration
            s_nxt.cal_st = ddzq_pkg::CAL_MEAS;
            s_nxt.cal_long = s_r.p2.a10;
            s_nxt.cal_age = 12'h000;
            s_nxt.step_cnt = ddzq_pkg::SHORT_STEP_MAX;
            s_nxt.meas_code = s_r.drv_code;
            if (!s_r.p2.a10) begin
              s_nxt.cal_cnt = SHORT_CYC;
            end else if (s_r.first_cal) begin
              s_nxt.cal_cnt = INIT_CYC;
              s_nxt.first_cal = 1'b0;
            end else begin
              s_nxt.cal_cnt = OPER_CYC;
            end
          end
        end
        ddzq_pkg::CMD_SRX: begin
          // Exit starts timers only
          s_nxt.srx_cnt = ddzq_pkg::SRX_EXIT_CYC;
          s_nxt.dll_cnt = ddzq_pkg::DLL_LOCK_CYC;
        end
        default: begin
        end
      endcase
    end

    // Data store ports
    mem_we = do_wr;
    mem_waddr = MEM_AW'({bi, s_r.p2.col});
    mem_wdata = wword;
    mem_wmask = chop ? ddzq_pkg::MASK_CHOP : ddzq_pkg::MASK_EIGHT;
    mem_raddr = MEM_AW'({bi, s_r.p2.col});

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data taken together
    if (S_AXI_AWREADY) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = ddzq_pkg::RESP_OKAY;
      case (S_AXI_AWADDR[3:0] | {4{|S_AXI_AWADDR[31:4]}})
        ddzq_pkg::ADDR_CTRL: begin
          if (S_AXI_WSTRB[0]) begin
            s_nxt.ctrl = S_AXI_WDATA[3:0] & ddzq_pkg::CTRL_MASK[3:0];
          end
        end
        ddzq_pkg::ADDR_STATUS: begin
          if (S_AXI_WSTRB[1]) begin
            err_clr = S_AXI_WDATA;
          end
        end
        ddzq_pkg::ADDR_CODE: begin
        end
        ddzq_pkg::ADDR_SPACING: begin
          if (S_AXI_WSTRB[0]) begin
            s_nxt.spacing[7:0] = S_AXI_WDATA[7:0];
          end
          if (S_AXI_WSTRB[1]) begin
            s_nxt.spacing[15:8] = S_AXI_WDATA[15:8];
          end
        end
        default: begin
          s_nxt.bresp = ddzq_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end

    // Error flags: set beats clear
    s_nxt.err = (s_r.err & ~err_clr[ddzq_pkg::ST_ERR_LSB +: ddzq_pkg::ST_ERR_W])
      | err_set[ddzq_pkg::ST_ERR_LSB +: ddzq_pkg::ST_ERR_W];

    // AXI4-Lite read
    if (S_AXI_ARVALID && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = ddzq_pkg::RESP_OKAY;
      case (S_AXI_ARADDR[3:0] | {4{|S_AXI_ARADDR[31:4]}})
        ddzq_pkg::ADDR_CTRL: s_nxt.rdata = {28'h000_0000, s_r.ctrl};
        ddzq_pkg::ADDR_STATUS: s_nxt.rdata = status_word(s_r);
        ddzq_pkg::ADDR_CODE: s_nxt.rdata = {18'h0_0000, s_r.odt_code, 2'h0, s_r.drv_code};
        ddzq_pkg::ADDR_SPACING: s_nxt.rdata = {16'h0000, s_r.spacing};
        default: begin
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rresp = ddzq_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s_r <= '0;
      s_r.cal_st <= ddzq_pkg::CAL_IDLE;
      s_r.first_cal <= 1'b1;
      s_r.drv_code <= ddzq_pkg::CODE_RESET;
      s_r.odt_code <= ddzq_pkg::CODE_RESET;
      s_r.meas_code <= ddzq_pkg::CODE_RESET;
      s_r.ctrl <= ddzq_pkg::CTRL_RESET[3:0];
      s_r.spacing <= {ddzq_pkg::CROSS_GROUP_SPACING_RST, ddzq_pkg::SAME_GROUP_SPACING_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data store

  ddzq_mem #(
    .DW(32),
    .AW(MEM_AW)
  ) u_mem (
    .clk(CORE_CLK),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .wmask(mem_wmask),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // Outputs
  assign RDATA = mem_rdata;
  assign RVALID = s_r.rd_pend;
  assign DRV_CODE = s_r.drv_code;
  assign ODT_CODE = s_r.odt_code;
  assign ZQ_CURRENT_EN = (s_r.cal_st == ddzq_pkg::CAL_MEAS);
  assign PARK_TERM_EN = 1'b1;
  assign CAL_BUSY = (s_r.cal_st != ddzq_pkg::CAL_IDLE);
  assign S_AXI_AWREADY = S_AXI_AWVALID && S_AXI_WVALID && !s_r.bvalid;
  assign S_AXI_WREADY = S_AXI_AWREADY;
  assign S_AXI_BVALID = s_r.bvalid;
  assign S_AXI_BRESP = s_r.bresp;
  assign S_AXI_ARREADY = !s_r.rvalid;
  assign S_AXI_RVALID = s_r.rvalid;
  assign S_AXI_RDATA = s_r.rdata;
  assign S_AXI_RRESP = s_r.rresp;

endmodule

`default_nettype wire

// *** tb/ddzq_chk.sv ***
// Port checker of the calibration block
`timescale 1ns/1ps
`default_nettype none
module ddzq_chk #(
  parameter logic [11:0] INIT_CYC = 12'h400,
  parameter logic [11:0] OPER_CYC = 12'h200,
  parameter logic [11:0] SHORT_CYC = 12'h080
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire ddzq_pkg::ddzq_pin_s PINS,
  input wire logic RVALID,
  input wire logic [5:0] DRV_CODE,
  input wire logic ZQ_CURRENT_EN,
  input wire logic PARK_TERM_EN,
  input wire logic CAL_BUSY
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  logic [11:0] cnt_r;
  logic first_r;
  logic long_r;
  logic [11:0] exp_w;
  ////////////////////////////////////////
  // Busy run length and the period plus one transfer cycle it should match
  assign exp_w = (long_r ? (first_r ? INIT_CYC : OPER_CYC) : SHORT_CYC) + 12'h001;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cnt_r <= 12'h000;
      first_r <= 1'b1;
      long_r <= 1'b0;
    end else begin
      cnt_r <= CAL_BUSY ? cnt_r + 12'h001 : 12'h000;
      if ($rose(CAL_BUSY)) begin
        long_r <= $past(PINS.a10, 3);
      end
      if ($fell(CAL_BUSY) && long_r) begin
        first_r <= 1'b0;
      end
    end
  end
  // Transfer cycle closes the calibration
  sequence xfer_s;
    CAL_BUSY ##1 !CAL_BUSY;
  endsequence
  ////////////////////////////////////////
  AST_PARK: assert property (PARK_TERM_EN) else $error("park termination off");
  AST_LEN: assert property ($fell(CAL_BUSY) |-> cnt_r == exp_w) else $error("cal length");
  AST_START: assert property ($rose(CAL_BUSY) |-> $past(PINS.cmd_valid && PINS.cmd == ddzq_pkg::CMD_ZQ, 3))
    else $error("cal without command");
  AST_CUR: assert property (ZQ_CURRENT_EN |-> CAL_BUSY) else $error("current outside cal");
  AST_OFF: assert property ($fell(ZQ_CURRENT_EN) |-> xfer_s) else $error("no transfer step");
  AST_CODE: assert property (!CAL_BUSY && !$past(CAL_BUSY) |-> $stable(DRV_CODE)) else $error("code moved");
  AST_RD: assert property (RVALID |-> !CAL_BUSY ##1 !RVALID) else $error("read pulse");
  AST_RDC: assert property (RVALID |-> $past(PINS.cmd_valid && PINS.cmd == ddzq_pkg::CMD_RD, 3))
    else $error("read without command");
endmodule
bind ddzq_top ddzq_chk #(.INIT_CYC(INIT_CYC), .OPER_CYC(OPER_CYC), .SHORT_CYC(SHORT_CYC)) i_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .PINS(PINS), .RVALID(RVALID), .DRV_CODE(DRV_CODE),
  .ZQ_CURRENT_EN(ZQ_CURRENT_EN), .PARK_TERM_EN(PARK_TERM_EN), .CAL_BUSY(CAL_BUSY));
`default_nettype wire

// *** tb/ddzq_ctl.sv ***
// Controller model that drives the command pins
`timescale 1ns/1ps
`default_nettype none
module ddzq_ctl (
  input wire logic clk,
  input wire logic busy,
  input wire logic rval,
  input wire logic [31:0] rdat,
  output var ddzq_pkg::ddzq_pin_s pins,
  output var logic [31:0] lrd,
  output var int rdn,
  output var int bsn
);
  ////////////////////////////////////////
  // Idle pins
  initial begin
    pins = '0;
    pins.cke = 1'b1;
    pins.wdata = 32'h5A5A_C3C3;
    rdn = 0;
    bsn = 0;
  end
  // Read capture, busy count
  always @(posedge clk) begin
    if (rval) begin
      lrd <= rdat;
      rdn <= rdn + 1;
    end
    if (busy) begin
      bsn <= bsn + 1;
    end
  end
  // One command pulse, then six-cycle spacing
  task automatic issue(input ddzq_pkg::ddzq_cmd_e c, input logic [3:0] bb, input logic [3:0] col,
    input logic a, input logic [31:0] d, input logic [1:0] v);
    @(posedge clk);
    {pins.cmd_valid, pins.cmd, pins.bg, pins.ba, pins.col} <= {1'b1, c, bb, col};
    {pins.a10, pins.a12, pins.wdata} <= {a, a, d};
    {pins.strobe_viol, pins.data_viol} <= v;
    @(posedge clk);
    {pins.cmd_valid, pins.cmd, pins.strobe_viol, pins.data_viol} <= 7'h00;
    pins.wdata <= ~d;
    repeat (4) @(posedge clk);
  endtask
  // Precharge, then calibrate and wait
  task automatic zq(input logic lng, input logic comp, output int n);
    int b;
    issue(ddzq_pkg::CMD_PREA, 4'h0, 4'h0, 1'b0, 32'h0, 2'h0);
    repeat (ddzq_pkg::PRECHARGE_CYC) @(posedge clk);
    pins.zq_comp <= comp;
    b = bsn;
    issue(ddzq_pkg::CMD_ZQ, 4'h0, 4'h0, lng, 32'h0, 2'h0);
    do @(negedge clk); while (busy);
    n = bsn - b;
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench of the calibration block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [11:0] IC = 12'h010;
  localparam logic [11:0] OC = 12'h008;
  localparam logic [11:0] SC = 12'h004;
  localparam logic [31:0] A_CT = 32'(ddzq_pkg::ADDR_CTRL);
  localparam logic [31:0] A_ST = 32'(ddzq_pkg::ADDR_STATUS);
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdt, rdat, lrd, st;
  logic awr, wrdy, bv, arr, rv, rval, cur, park, busy;
  logic [1:0] br, rr, r;
  logic [5:0] drv, d0;
  ddzq_pkg::ddzq_pin_s pins;
  int err_count = 0, n_checks = 0, cyc = 0, rdn, bsn, n;
  ////////////////////////////////////////
  // Clock and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count = err_count + 1;
      test_done();
    end
  end
  ddzq_ctl i_ctl (.clk(clk), .busy(busy), .rval(rval), .rdat(rdat), .pins(pins), .lrd(lrd), .rdn(rdn), .bsn(bsn));
  ddzq_top #(.INIT_CYC(IC), .OPER_CYC(OC), .SHORT_CYC(SC)) i_dut (.CORE_CLK(clk), .RST(rst), .PINS(pins),
    .RDATA(rdat), .RVALID(rval), .DRV_CODE(drv), .ODT_CODE(), .ZQ_CURRENT_EN(cur), .PARK_TERM_EN(park),
    .CAL_BUSY(busy), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv), .S_AXI_BREADY(brd),
    .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rrd), .S_AXI_RDATA(rdt), .S_AXI_RRESP(rr));
  ////////////////////////////////////////
  // Compare, report, finish
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Register bus cycles
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    {awv, wv, brd} <= 3'h7;
    {awa, wd} <= {a, d};
    do @(negedge clk); while (!(awr && wrdy));
    @(posedge clk);
    {awv, wv} <= 2'h0;
    do @(negedge clk); while (!bv);
    r = br;
    @(posedge clk);
    brd <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a);
    @(posedge clk);
    {arv, rrd, ara} <= {2'h3, a};
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (!rv);
    {st, r} = {rdt, rr};
    @(posedge clk);
    rrd <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] col);
    repeat (4) @(posedge clk);
    i_ctl.issue(ddzq_pkg::CMD_RD, 4'h0, col, 1'b0, 32'h0, 2'h0);
  endtask
  ////////////////////////////////////////
  // Reset state and register map
  task automatic t_reset();
    check("drv code", drv, 32'h20);
    check("park", park, 32'h1);
    axi_rd(32'(ddzq_pkg::ADDR_SPACING));
    check("spacing", st, 32'h0406);
    axi_rd(A_ST);
    check("first flag", st[ddzq_pkg::ST_FIRST], 32'h1);
    axi_rd(32'h10);
    check("unmapped", r, ddzq_pkg::RESP_SLVERR);
  endtask
  // Long, later long after exit, short
  task automatic t_cal();
    i_ctl.zq(1'b1, 1'b1, n);
    check("init len", n, IC + 1);
    check("code up", drv > 6'h20, 32'h1);
    check("current", cur, 32'h0);
    i_ctl.issue(ddzq_pkg::CMD_SRX, 4'h0, 4'h0, 1'b0, 32'h0, 2'h0);
    repeat (ddzq_pkg::SRX_EXIT_CYC) @(posedge clk);
    i_ctl.zq(1'b1, 1'b1, n);
    check("oper len", n, OC + 1);
    d0 = drv;
    i_ctl.zq(1'b0, 1'b0, n);
    check("short len", n, SC + 1);
    check("short step", (drv < d0) && (d0 - drv <= ddzq_pkg::SHORT_STEP_MAX), 32'h1);
  endtask
  // Refused with an open bank
  task automatic t_refuse();
    n = bsn;
    i_ctl.issue(ddzq_pkg::CMD_ACT, 4'h0, 4'h0, 1'b0, 32'h0, 2'h0);
    i_ctl.issue(ddzq_pkg::CMD_ZQ, 4'h0, 4'h0, 1'b1, 32'h0, 2'h0);
    check("no cal", bsn, n);
    axi_rd(A_ST);
    check("refused", st[ddzq_pkg::ST_ZQ_REFUSED], 32'h1);
    axi_wr(A_ST, 32'h3F00);
    axi_rd(A_ST);
    check("cleared", st[ddzq_pkg::ST_ZQ_REFUSED], 32'h0);
  endtask
  // Every burst mode and select bit
  task automatic t_modes();
    logic [1:0] m;
    logic a;
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? ddzq_pkg::MODE_EIGHT : (i == 1) ? ddzq_pkg::MODE_CHOP : ddzq_pkg::MODE_OTF;
      a = (i == 3);
      v = 32'hC3A5_5A00 + 32'(i);
      axi_wr(A_CT, 32'h0);
      i_ctl.issue(ddzq_pkg::CMD_WR, 4'h0, 4'(i), 1'b0, 32'h0, 2'h0);
      axi_wr(A_CT, {30'h0, m});
      i_ctl.issue(ddzq_pkg::CMD_WR, 4'h0, 4'(i), a, v, 2'h0);
      rd(4'(i));
      check("burst", lrd, (i == 1 || i == 2) ? v & 32'hFFFF : v);
    end
  endtask
  // Violations, recovery after precharge
  task automatic t_viol();
    axi_wr(A_CT, 32'h0);
    axi_wr(A_ST, 32'h3F00);
    i_ctl.issue(ddzq_pkg::CMD_WR, 4'h0, 4'h4, 1'b0, 32'h1234_5678, 2'h0);
    i_ctl.issue(ddzq_pkg::CMD_WR, 4'h0, 4'h5, 1'b0, 32'h0F0F_0F0F, 2'h1);
    rd(4'h5);
    check("bad loc", lrd, 32'h0F0F_0F0F ^ ddzq_pkg::CORRUPT_PAT);
    rd(4'h4);
    check("other loc", lrd, 32'h1234_5678);
    n = rdn;
    i_ctl.issue(ddzq_pkg::CMD_WR, 4'h0, 4'h6, 1'b0, 32'h0, 2'h2);
    i_ctl.issue(ddzq_pkg::CMD_WR, 4'h0, 4'h7, 1'b0, 32'h0, 2'h0);
    rd(4'h6);
    check("read ok", rdn, n + 1);
    axi_rd(A_ST);
    check("status", st[13:8], 32'h0);
    check("offender", st[ddzq_pkg::ST_OFFENDER], 32'h1);
    i_ctl.issue(ddzq_pkg::CMD_PREA, 4'h0, 4'h0, 1'b0, 32'h0, 2'h0);
    axi_rd(A_ST);
    check("offender off", st[ddzq_pkg::ST_OFFENDER], 32'h0);
    i_ctl.issue(ddzq_pkg::CMD_ACT, 4'h0, 4'h0, 1'b0, 32'h0, 2'h0);
    i_ctl.issue(ddzq_pkg::CMD_WR, 4'h0, 4'h6, 1'b0, 32'h6666_9999, 2'h0);
    rd(4'h6);
    check("good write", lrd, 32'h6666_9999);
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_cal();
    t_refuse();
    t_modes();
    t_viol();
    test_done();
  end
endmodule
`default_nettype wire
